/* File: design/dms_pkg.sv */
//==============================================================
// Shared constants and types
//==============================================================
package dms_pkg;
   localparam int DMS_ADDR_W     = 13;
   localparam int DMS_BANK_W     = 2;
   localparam int DMS_COL_W      = 12;
   localparam int DMS_DATA_W     = 72;
   localparam int DMS_FIFO_DEPTH = 8;
   // Mode word field positions
   localparam int DMS_BL_LSB     = 0;
   localparam int DMS_ORDER_POS  = 3;
   localparam int DMS_LAT_LSB    = 4;
   localparam int DMS_OPM_LSB    = 7;
   localparam int DMS_LOOP_POS   = 8;
   localparam int DMS_AUTOPRE_POS = 10;
   // Mode word reset value
   localparam logic [12:0] DMS_MODE_RESET = 13'h0022;
   // Burst length codes
   localparam logic [2:0] DMS_BL2 = 3'h1;
   localparam logic [2:0] DMS_BL4 = 3'h2;
   localparam logic [2:0] DMS_BL8 = 3'h3;
   // Read latency codes
   localparam logic [2:0] DMS_LAT2  = 3'h2;
   localparam logic [2:0] DMS_LAT3  = 3'h3;
   localparam logic [2:0] DMS_LAT25 = 3'h6;
   // Mode-select bank value
   localparam logic [1:0] DMS_BANK_MODE = 2'h0;
   // Self-timed precharge length in cycles
   localparam int DMS_PRE_CYC = 3;
   // Presence-detect store
   localparam int DMS_PD_BYTES = 256;
   localparam int DMS_PD_HALF  = 128;
   localparam logic [3:0] DMS_PD_DEV = 4'hA;

   // Command encoding: {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      DMS_CMD_ACT  = 4'b0011,
      DMS_CMD_RD   = 4'b0101,
      DMS_CMD_WR   = 4'b0100,
      DMS_CMD_MRS  = 4'b0000,
      DMS_CMD_NOP  = 4'b0111
   } dms_cmd_t;

   typedef struct packed {
      logic [3:0]            cmd;
      logic [DMS_BANK_W-1:0] bank;
      logic [DMS_ADDR_W-1:0] addr;
   } dms_ca_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] len;
      logic       order;
      logic [2:0] lat;
      logic       loop_rst;
   } dms_mode_t;
endpackage

/* File: design/dms_fifo.sv */
`timescale 1ns/10ps
//==============================================================
// Word FIFO with valid/ready on both sides
//==============================================================
module dms_fifo
   import dms_pkg::*;
#(
   parameter int WIDTH = 72,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   //==============================================================
   // Storage and pointers
   //==============================================================
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: design/dms_module.sv */
`timescale 1ns/10ps
// How it works
// - Command, address and control sampled only on rising clock edges.
// - Two data words move per clock, one per half cycle.
// - Module drives strobe on reads edge-aligned; controller drives it on writes.
// - Write data taken on both strobe edges; read data launched on both.
// - Read/write address selects bank and starting column.
// - Burst lengths of two, four or eight are supported.
// - Auto precharge starts a self-timed precharge after the burst.
// - Input register delays command and address by one clock.
// - Presence-detect store holds 256 bytes; upper half writable.
// - Presence-detect store is an I2C slave; straps pick the address.
// - Hardware write protect is held inactive.
// - Mode word holds until rewritten; the loop reset bit self-clears.
// - A mode write leaves stored memory unchanged.
// - Mode fields: length, order, latency, operating mode.
// - Mode write only when both bank-select bits are zero.
// - Length codes 001, 010, 011 give two, four, eight.
// - Order bit zero is sequential, one is interleaved.
// - Operating bits all zero is normal; loop reset bit alone resets loop.
// - Burst stays in an aligned block and wraps.
// - Sequential is start plus k; interleaved is start xor k.
// - One burst length governs reads and writes.
// - First read data at command edge plus whole-cycle latency plus two.
module dms_module
   import dms_pkg::*;
#(
   parameter int DATA_W = DMS_DATA_W,
   parameter int DEPTH  = DMS_FIFO_DEPTH
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire dms_ca_t           ca_in,
   input  wire logic [DATA_W-1:0] wr_rise,
   input  wire logic [DATA_W-1:0] wr_fall,
   input  wire logic              strobe_in,
   output logic [DATA_W-1:0]      rd_rise,
   output logic [DATA_W-1:0]      rd_fall,
   output logic                   rd_valid,
   input  wire logic              rd_ready,
   output logic                   strobe_out,
   output logic                   strobe_oe,
   output logic                   dq_oe,
   output logic                   loop_reset_pulse,
   output logic                   precharge_busy,
   output logic                   mode_error,
   input  wire logic [2:0]        spd_slave_select_straps,
   input  wire logic              scl,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   output logic                   write_protect
);
   localparam int CW = DMS_COL_W;

   //==============================================================
   // Burst address functions
   //==============================================================
   // Number of columns in a burst from the length code
   function automatic logic [3:0] burst_cols(input logic [2:0] code);
      unique case (code)
         DMS_BL2: burst_cols = 4'h2;
         DMS_BL4: burst_cols = 4'h4;
         default: burst_cols = 4'h8;
      endcase
   endfunction

   // Column of the k-th beat within the aligned block
   function automatic logic [CW-1:0] beat_col(input logic [CW-1:0] start,
                                              input logic [2:0] k,
                                              input logic [3:0] len,
                                              input logic order);
      logic [2:0] low;
      logic [2:0] msk;
      msk = 3'(len - 4'h1);
      low = order ? (start[2:0] ^ k) : (start[2:0] + k);
      beat_col = {start[CW-1:3], (start[2:0] & ~msk) | (low & msk)};
   endfunction

   //==============================================================
   // Input register stage
   //==============================================================
   dms_ca_t ca_q;
   // Latch on the rising edge, forward next edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ca_q <= '{cmd: DMS_CMD_NOP, bank: '0, addr: '0};
      end else begin
         ca_q <= ca_in;
      end
   end

   //==============================================================
   // Mode word
   //==============================================================
   logic [12:0] operating_mode_setting;
   logic [2:0]  burst_len_code;
   logic        burst_order_select;
   logic [2:0]  read_latency_setting;
   logic [5:0]  opm;
   logic        idle;
   assign burst_len_code       = operating_mode_setting[DMS_BL_LSB +: 3];
   assign burst_order_select   = operating_mode_setting[DMS_ORDER_POS];
   assign read_latency_setting = operating_mode_setting[DMS_LAT_LSB +: 3];
   assign opm                  = operating_mode_setting[DMS_OPM_LSB +: 6];

   // Mode write; loop reset bit self-clears one cycle later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         operating_mode_setting <= DMS_MODE_RESET;
      end else if (ca_q.cmd == DMS_CMD_MRS && ca_q.bank == DMS_BANK_MODE) begin
         operating_mode_setting <= ca_q.addr;
      end else begin
         operating_mode_setting[DMS_LOOP_POS] <= 1'b0;
      end
   end

   assign loop_reset_pulse = operating_mode_setting[DMS_LOOP_POS];

   // Reserved-code flag
   always_comb begin
      mode_error = 1'b0;
      if (!(burst_len_code inside {DMS_BL2, DMS_BL4, DMS_BL8})) mode_error = 1'b1;
      if (!(read_latency_setting inside {DMS_LAT2, DMS_LAT3, DMS_LAT25})) begin
         mode_error = 1'b1;
      end
      if (opm != 6'h00 && opm != 6'h02) mode_error = 1'b1;
   end

   //==============================================================
   // Burst engine
   //==============================================================
   typedef enum logic [1:0] {
      DMS_IDLE  = 2'b00,
      DMS_WAIT  = 2'b01,
      DMS_READ  = 2'b10,
      DMS_WRITE = 2'b11
   } dms_state_t;

   dms_state_t      state;
   logic [CW-1:0]   start_col;
   logic [1:0]      cur_bank;
   logic            auto_pre;
   logic [2:0]      beat;
   logic [3:0]      len_q;
   logic [2:0]      wait_cnt;
   logic [1:0]      pre_cnt;
   logic [3:0]      beats_total;
   logic [2:0]      lat_cyc;
   logic            burst_done;
   logic            fifo_ready;
   logic [CW-1:0]   col_a;
   logic [CW-1:0]   col_b;

   assign beats_total = burst_cols(burst_len_code);
   // Whole cycles to first data; half-cycle code rounds down to two
   assign lat_cyc     = (read_latency_setting == DMS_LAT3) ? 3'h3 : 3'h2;
   assign burst_done  = ({1'b0, beat} + 4'h2 >= len_q);
   assign idle        = (state == DMS_IDLE);
   assign write_protect = 1'b0;

   // Burst sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= DMS_IDLE;
         start_col <= '0;
         cur_bank  <= '0;
         auto_pre  <= 1'b0;
         beat      <= '0;
         len_q     <= 4'h2;
         wait_cnt  <= '0;
      end else begin
         unique case (state)
            DMS_IDLE: begin
               beat <= '0;
               if (ca_q.cmd == DMS_CMD_RD || ca_q.cmd == DMS_CMD_WR) begin
                  start_col <= {ca_q.addr[11], ca_q.addr[9:0], 1'b0} >> 1;
                  cur_bank  <= ca_q.bank;
                  auto_pre  <= ca_q.addr[DMS_AUTOPRE_POS];
                  len_q     <= beats_total;
                  wait_cnt  <= lat_cyc - 3'h1;
                  state     <= (ca_q.cmd == DMS_CMD_RD) ? DMS_WAIT : DMS_WRITE;
               end
            end
            DMS_WAIT: begin
               if (wait_cnt <= 3'h1) state <= DMS_READ;
               else wait_cnt <= wait_cnt - 3'h1;
            end
            DMS_READ: begin
               if (fifo_ready) begin
                  beat <= beat + 3'h2;
                  if (burst_done) state <= DMS_IDLE;
               end
            end
            DMS_WRITE: begin
               if (strobe_in) begin
                  beat <= beat + 3'h2;
                  if (burst_done) state <= DMS_IDLE;
               end
            end
         endcase
      end
   end

   // Self-timed precharge after an auto-precharge burst
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= '0;
      end else if ((state == DMS_READ && fifo_ready || state == DMS_WRITE && strobe_in)
                   && burst_done && auto_pre) begin
         pre_cnt <= 2'(DMS_PRE_CYC);
      end else if (pre_cnt != '0) begin
         pre_cnt <= pre_cnt - 2'h1;
      end
   end
   assign precharge_busy = (pre_cnt != '0);

   //==============================================================
   // Column storage: one double-width core access per cycle
   //==============================================================
   localparam int NCOL = 64;
   logic [DATA_W-1:0]   core [NCOL]; // One word per bank and low four column bits, any later order reads back
   logic [2*DATA_W-1:0] rd_word;
   assign col_a = beat_col(start_col, beat, len_q, burst_order_select);
   assign col_b = beat_col(start_col, beat + 3'h1, len_q, burst_order_select);

   // Write pair captured on both strobe edges
   always_ff @(posedge clk) begin
      if (state == DMS_WRITE && strobe_in) begin
         core[{cur_bank, col_a[3:0]}] <= wr_rise;
         core[{cur_bank, col_b[3:0]}] <= wr_fall;
      end
   end
   assign rd_word = {core[{cur_bank, col_b[3:0]}], core[{cur_bank, col_a[3:0]}]};

   //==============================================================
   // Read FIFO and pin launch
   //==============================================================
   logic fifo_valid;
   logic [2*DATA_W-1:0] fifo_data;
   dms_fifo #(
      .WIDTH (2*DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (rd_word),
      .in_valid  (state == DMS_READ),
      .in_ready  (fifo_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (rd_ready)
   );

   // Registered output pair, strobe edge-aligned
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_rise    <= '0;
         rd_fall    <= '0;
         rd_valid   <= 1'b0;
         strobe_out <= 1'b0;
      end else begin
         rd_valid   <= fifo_valid && rd_ready;
         strobe_out <= fifo_valid && rd_ready;
         if (fifo_valid && rd_ready) begin
            rd_rise <= fifo_data[DATA_W-1:0];
            rd_fall <= fifo_data[2*DATA_W-1:DATA_W];
         end
      end
   end
   assign strobe_oe = rd_valid;
   assign dq_oe     = rd_valid;

   //==============================================================
   // Presence-detect store (I2C slave)
   //==============================================================
   typedef enum logic [2:0] {
      DMS_PD_IDLE = 3'b000,
      DMS_PD_DEVA = 3'b001,
      DMS_PD_ADDR = 3'b010,
      DMS_PD_DATA = 3'b011,
      DMS_PD_READ = 3'b100,
      DMS_PD_ACK  = 3'b101
   } dms_pd_t;

   logic [7:0]  presence_detect_store [DMS_PD_BYTES];
   dms_pd_t     pd_state;
   dms_pd_t     pd_after;
   logic        scl_q;
   logic        sda_q;
   logic [7:0]  shreg;
   logic [3:0]  bitn;
   logic [7:0]  pd_ptr;
   logic        pd_rnw;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   assign scl_rise = scl && !scl_q;
   assign scl_fall = !scl && scl_q;
   assign start_c  = scl && scl_q && sda_q && !sda_in;
   assign stop_c   = scl && scl_q && !sda_q && sda_in;

   // Slave protocol, byte writes only to the upper half
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1; sda_q <= 1'b1; pd_state <= DMS_PD_IDLE; pd_after <= DMS_PD_IDLE;
         shreg <= '0; bitn <= '0; pd_ptr <= '0; pd_rnw <= 1'b0;
         sda_out <= 1'b0; sda_oe <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
         if (start_c) begin
            pd_state <= DMS_PD_DEVA; bitn <= '0; sda_oe <= 1'b0;
         end else if (stop_c) begin
            pd_state <= DMS_PD_IDLE; sda_oe <= 1'b0;
         end else if (scl_rise && pd_state != DMS_PD_IDLE && pd_state != DMS_PD_ACK
                      && pd_state != DMS_PD_READ) begin
            shreg <= {shreg[6:0], sda_in};
            bitn  <= bitn + 4'h1;
         end else if (scl_fall) begin
            unique case (pd_state)
               DMS_PD_DEVA: if (bitn == 4'h8) begin
                  bitn <= '0;
                  if (shreg[7:1] == {DMS_PD_DEV, spd_slave_select_straps}) begin
                     pd_rnw <= shreg[0]; sda_oe <= 1'b1; sda_out <= 1'b0;
                     pd_after <= shreg[0] ? DMS_PD_READ : DMS_PD_ADDR;
                     pd_state <= DMS_PD_ACK;
                  end else pd_state <= DMS_PD_IDLE;
               end
               DMS_PD_ADDR, DMS_PD_DATA: if (bitn == 4'h8) begin
                  bitn <= '0; sda_oe <= 1'b1; sda_out <= 1'b0;
                  if (pd_state == DMS_PD_ADDR) pd_ptr <= shreg;
                  else begin
                     if (pd_ptr >= 8'(DMS_PD_HALF) && !write_protect) begin
                        presence_detect_store[pd_ptr] <= shreg;
                     end
                     pd_ptr <= pd_ptr + 8'h1;
                  end
                  pd_after <= DMS_PD_DATA; pd_state <= DMS_PD_ACK;
               end
               DMS_PD_ACK: begin
                  bitn <= '0;
                  sda_oe <= pd_after == DMS_PD_READ && !presence_detect_store[pd_ptr][7];
                  sda_out <= 1'b0; pd_state <= pd_after;
                  shreg <= presence_detect_store[pd_ptr];
               end
               DMS_PD_READ: if (bitn == 4'h7) begin
                  sda_oe <= 1'b0; pd_ptr <= pd_ptr + 8'h1; pd_state <= DMS_PD_IDLE;
               end else begin
                  bitn <= bitn + 4'h1; shreg <= {shreg[6:0], 1'b0};
                  sda_oe <= !shreg[6]; sda_out <= 1'b0;
               end
               default: ;
            endcase
         end
      end
   end
endmodule

/* File: tb/dms_monitor.sv */
`timescale 1ns/10ps
//==========================================
// Port checker for the module
module dms_monitor
   import dms_pkg::*;
(
   input wire logic    clk,
   input wire logic    rst_n,
   input wire dms_ca_t ca_in,
   input wire logic    rd_valid,
   input wire logic    strobe_out,
   input wire logic    strobe_oe,
   input wire logic    dq_oe,
   input wire logic    loop_reset_pulse,
   input wire logic    precharge_busy,
   input wire logic    mode_error,
   input wire logic    write_protect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Mode-set commands to either register
   wire mrs0 = ca_in.cmd == DMS_CMD_MRS && ca_in.bank == DMS_BANK_MODE;
   wire mrs1 = ca_in.cmd == DMS_CMD_MRS && ca_in.bank != DMS_BANK_MODE;

   property p_oe; strobe_oe == rd_valid && dq_oe == rd_valid; endproperty
   a_oe: assert property (p_oe) else $error("enables differ from read valid");
   property p_strobe; strobe_out |-> strobe_oe; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe toggles undriven");
   property p_wp; write_protect == 1'b0; endproperty
   a_wp: assert property (p_wp) else $error("write protect active");
   property p_loop; mrs0 && ca_in.addr[8] |-> ##[1:3] loop_reset_pulse; endproperty
   a_loop: assert property (p_loop) else $error("no loop reset pulse");
   property p_once; loop_reset_pulse |=> !loop_reset_pulse; endproperty
   a_once: assert property (p_once) else $error("loop reset bit not cleared");
   property p_bad; mrs0 && ca_in.addr[2:0] == 3'h0 |-> ##[1:3] mode_error; endproperty
   a_bad: assert property (p_bad) else $error("reserved length accepted");
   property p_ext; mrs1 && !mode_error |=> !mode_error [*3]; endproperty
   a_ext: assert property (p_ext) else $error("extended write hit mode");
   property p_lat; ca_in.cmd == DMS_CMD_RD && !rd_valid |-> ##[3:30] rd_valid; endproperty
   a_lat: assert property (p_lat) else $error("read data late");
   property p_pre; $rose(precharge_busy) |-> precharge_busy [*3] ##1 !precharge_busy; endproperty
   a_pre: assert property (p_pre) else $error("precharge length wrong");
   property p_first; ca_in.cmd == DMS_CMD_RD |-> !rd_valid [*5]; endproperty
   a_first: assert property (p_first) else $error("read data too early");
endmodule

/* File: tb/dms_host.sv */
`timescale 1ns/10ps
//==========================================
// Controller model on the command side
module dms_host
   import dms_pkg::*;
(
   input  wire logic   clk,
   output dms_ca_t     ca_in,
   output logic [71:0] wr_rise,
   output logic [71:0] wr_fall,
   output logic        strobe_in
);
   // Idle bus at time zero
   initial begin
      ca_in = {DMS_CMD_NOP, 2'h0, 13'h0000};
      wr_rise = '0;
      wr_fall = '1;
      strobe_in = 1'b0;
   end
   // One command for one cycle; released address shows its inverse
   task send(input logic [3:0] cmd, input logic [1:0] bank, input logic [12:0] addr);
      @(posedge clk);
      ca_in <= {cmd, bank, addr};
      @(posedge clk);
      ca_in <= {DMS_CMD_NOP, ~bank, ~addr};
   endtask
   // Mode write only from idle, then a settle wait
   task mode(input logic [12:0] word);
      send(DMS_CMD_MRS, DMS_BANK_MODE, word);
      repeat (4) @(posedge clk);
   endtask
   // Row open before every access
   task access(input logic [3:0] cmd, input logic [12:0] addr);
      send(DMS_CMD_ACT, 2'h0, 13'h0005);
      repeat (2) @(posedge clk);
      send(cmd, 2'h0, addr);
   endtask
   // Write pairs with the strobe, then lines go to inverse
   task put(input logic [71:0] w [8], input int n);
      for (int p = 0; p < n; p++) begin
         @(posedge clk);
         strobe_in <= 1'b1;
         wr_rise <= w[2*p];
         wr_fall <= w[2*p+1];
      end
      @(posedge clk);
      strobe_in <= 1'b0;
      wr_rise <= ~wr_rise;
      wr_fall <= ~wr_fall;
   endtask
endmodule

/* File: tb/dms_module_bench.sv */
`timescale 1ns/10ps
//==========================================
// Self-checking bench for the module
module dms_module_bench
   import dms_pkg::*;
;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          rd_ready = 1'b1;
   logic [2:0]    straps;
   dms_ca_t       ca_in;
   logic [71:0]   wr_rise, wr_fall, rd_rise, rd_fall;
   logic          strobe_in, rd_valid, strobe_out, strobe_oe, dq_oe;
   logic          loop_reset_pulse, precharge_busy, mode_error, write_protect;
   int            seed = 52671;
   int            fails = 0;
   int            total_checks = 0;
   int            cycles = 0;
   logic [71:0]   mem [8];
   logic [143:0]  expq [$];
   logic [2:0]    cur_len = DMS_BL4;
   logic          cur_ord = 1'b0;
   logic [95:0]   r;
   logic [2:0]    lats [3] = '{DMS_LAT2, DMS_LAT3, DMS_LAT25};
   logic [12:0]   bad [4] = '{13'h0000, 13'h0027, 13'h0072, 13'h0222};
   logic          scl = 1'b1;
   logic          sda_m = 1'b1;
   logic          sda_out, sda_oe;
   logic [7:0]    rx, pdb;
   wire           sda_bus = sda_m & ~(sda_oe & ~sda_out); // Open drain with pull-up

   dms_host HOST (.clk(clk), .ca_in(ca_in), .wr_rise(wr_rise), .wr_fall(wr_fall),
                  .strobe_in(strobe_in));
   dms_module #(.DATA_W(72), .DEPTH(8)) DUT (
      .clk(clk), .rst_n(rst_n), .ca_in(ca_in), .wr_rise(wr_rise), .wr_fall(wr_fall),
      .strobe_in(strobe_in), .rd_rise(rd_rise), .rd_fall(rd_fall), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .strobe_out(strobe_out), .strobe_oe(strobe_oe), .dq_oe(dq_oe),
      .loop_reset_pulse(loop_reset_pulse), .precharge_busy(precharge_busy),
      .mode_error(mode_error), .spd_slave_select_straps(straps), .scl(scl),
      .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect));

   //==========================================
   // Clock, random back-pressure and time limit
   always #5 clk = ~clk;
   initial straps = 3'($random(seed));
   always @(posedge clk) rd_ready <= ($random(seed) & 3) != 0;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         end_of_test();
      end
   end

   //==========================================
   // Checking and stimulus tasks
   task check(input logic [143:0] seen, input logic [143:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function logic [2:0] col(input logic [2:0] s, input int k, input int n);
      logic [2:0] m;
      m = 3'(n - 1);
      col = cur_ord ? s ^ 3'(k) : (s & ~m) | ((s + 3'(k)) & m);
   endfunction
   task set_mode(input logic [2:0] len, input logic ord, input logic [2:0] lat, input logic lp);
      cur_len = len;
      cur_ord = ord;
      HOST.mode({4'h0, lp, 1'b0, lat, ord, len});
   endtask
   task wr(input int n);
      for (int c = 0; c < 2*n; c++) begin
         r = {$random(seed), $random(seed), $random(seed)};
         mem[c] = r[71:0];
      end
      HOST.access(DMS_CMD_WR, 13'h0000);
      HOST.put(mem, n);
      repeat (4) @(posedge clk);
   endtask
   task rd(input logic [2:0] start, input logic ap);
      int n;
      n = 1 << cur_len;
      for (int p = 0; p < n/2; p++)
         expq.push_back({mem[col(start, 2*p, n)], mem[col(start, 2*p+1, n)]});
      HOST.access(DMS_CMD_RD, {2'h0, ap, 7'h00, start});
      for (int w = 0; w < 200 && expq.size() > 0; w++)
         @(posedge clk);
      check(144'(expq.size()), 144'h0);
      repeat (6) @(posedge clk);
   endtask
   // I2C bit: data set while clock low, sampled while high; cnd makes start or stop
   task i2c_bit(input logic b, input logic cnd);
      @(posedge clk) sda_m <= b;
      repeat (2) @(posedge clk);
      scl <= 1'b1;
      repeat (2) @(posedge clk);
      rx = {rx[6:0], sda_bus};
      if (cnd)
         sda_m <= !b;
      repeat (2) @(posedge clk);
      scl <= cnd && !b;
      repeat (2) @(posedge clk);
   endtask
   // I2C byte out, then the acknowledge bit compared
   task i2c_byte(input logic [7:0] d, input logic nak);
      for (int i = 7; i >= 0; i--)
         i2c_bit(d[i], 1'b0);
      i2c_bit(1'b1, 1'b0);
      check(144'(rx[0]), 144'(nak));
   endtask

   //==========================================
   // Read data watcher against the oldest note
   always @(posedge clk) begin
      if (rst_n === 1'b1 && rd_valid === 1'b1) begin
         if (expq.size() == 0)
            check(144'(rd_valid), 144'h0);
         else
            check({rd_rise, rd_fall}, expq.pop_front());
      end
   end

   //==========================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(144'(mode_error), 144'h0);
      wr(2);
      rd(3'h1, 1'b0);
      $display("test reset_mode done");
      set_mode(DMS_BL8, 1'b0, DMS_LAT3, 1'b0);
      wr(4);
      for (int l = 0; l < 3; l++)
         for (int b = 1; b < 4; b++)
            for (int o = 0; o < 2; o++) begin
               set_mode(3'(b), o[0], lats[l], b == 3);
               rd(3'($random(seed)), o[0]);
            end
      $display("test burst_table done");
      HOST.send(DMS_CMD_MRS, 2'h1, 13'h0000);
      repeat (3) @(posedge clk);
      check(144'(mode_error), 144'h0);
      for (int i = 0; i < 4; i++) begin
         HOST.mode(bad[i]);
         check(144'(mode_error), 144'h1);
      end
      set_mode(DMS_BL4, 1'b1, DMS_LAT2, 1'b0);
      check(144'(mode_error), 144'h0);
      rd(3'h1, 1'b1);
      $display("test reserved_codes done");
      // Wrong straps refused, customer byte written, pointer reset, byte read back
      pdb = 8'($random(seed));
      for (int t = 0; t < 4; t++) begin
         i2c_bit(1'b1, 1'b1);
         i2c_byte({DMS_PD_DEV, t == 0 ? ~straps : straps, t == 3}, t == 0);
         if (t == 1 || t == 2)
            i2c_byte(8'h9C, 1'b0);
         if (t == 1)
            i2c_byte(pdb, 1'b0);
         if (t == 3) begin
            for (int i = 0; i < 8; i++)
               i2c_bit(1'b1, 1'b0);
            check(144'(rx), 144'(pdb));
            i2c_bit(1'b1, 1'b0);
         end
         i2c_bit(1'b0, 1'b1);
      end
      $display("test presence_detect done");
      end_of_test();
   end
endmodule

bind dms_module dms_monitor MON (
   .clk(clk), .rst_n(rst_n), .ca_in(ca_in), .rd_valid(rd_valid), .strobe_out(strobe_out),
   .strobe_oe(strobe_oe), .dq_oe(dq_oe), .loop_reset_pulse(loop_reset_pulse),
   .precharge_busy(precharge_busy), .mode_error(mode_error), .write_protect(write_protect));
